// ==== cem_pkg.sv ====
package cem_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_MODE_CONTROL = 4'h0;
    localparam logic [3:0] IDX_COMMAND = 4'h1;
    localparam logic [3:0] IDX_STATUS = 4'h2;
    localparam logic [3:0] IDX_INTERRUPT_FLAGS = 4'h3;
    localparam logic [3:0] IDX_INTERRUPT_ENABLES = 4'h4;
    localparam logic [3:0] IDX_WARNING_LIMIT = 4'hD;
    localparam logic [3:0] IDX_RX_ERROR_COUNT = 4'hE;
    localparam logic [3:0] IDX_TX_ERROR_COUNT = 4'hF;
    // mode_control fields
    localparam int MC_RESET = 0;
    localparam int MC_LISTEN = 1;
    localparam int MC_LOOPBACK = 2;
    localparam int MC_DUAL = 3;
    // command fields
    localparam int CMD_TX = 0;
    localparam int CMD_CANCEL = 1;
    localparam int CMD_RELEASE = 2;
    localparam int CMD_CLR_OVR = 3;
    localparam int CMD_SELF_RX = 4;
    // status fields
    localparam int ST_RX_PEND = 0;
    localparam int ST_OVERRUN = 1;
    localparam int ST_TX_FREE = 2;
    localparam int ST_OVERLOAD = 3;
    localparam int ST_RX_ACT = 4;
    localparam int ST_TX_ACT = 5;
    localparam int ST_WARN = 6;
    localparam int ST_BUS_OFF = 7;
    // interrupt flag fields
    localparam int IF_RX = 0;
    localparam int IF_TX = 1;
    localparam int IF_ERR = 2;
    localparam int IF_OVR = 3;
    localparam logic [3:0] IRQ_MASK = 4'hF;
    // reset values and the receive count ceiling
    localparam logic [7:0] MODE_RESET_VAL = 8'h01;
    localparam logic [7:0] WARN_LIMIT_RESET = 8'h60;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    // bus-free occurrences needed to leave bus-off
    localparam logic [7:0] BUS_FREE_COUNT = 8'h80;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_PEND = 3'b010,
        TX_BUSY = 3'b100
    } cem_tx_state_e;
endpackage

// ==== cem_ctrl.sv ====
// What this block does
// - writing reset-mode bit enters reset mode, aborts transfers; resets to one
// - entering bus-off forces the reset-mode bit to one
// - limit and error-count registers reachable only in reset mode
// - listen-only drops acknowledge and freezes error counters; reset-mode write
// - loopback-check mode counts a transmission good without acknowledge
// - dual-filter bit picks two short filters or one 32-bit filter
// - command bit 0 requests transmission; self-clearing; zero does nothing
// - command bit 1 cancels a pending, unstarted request; transmit flag follows
// - cancel with transmit or self-receive means one single-shot attempt
// - command bit 2 releases the current receive message
// - overrun flag travels with the message, cleared by command bit 3
// - self-receive command transmits and receives on the first attempt only
// - self-receive outside loopback mode acts as plain transmit
// - receive-pending follows fifo contents, drops on release
// - transmit-buffer-free is zero while a message waits or transmits
// - overload flag sets on overload frame, clears on next data frame
// - status bits 4 and 5 show receive and transmit activity
// - warning flag when either error count reaches the limit
// - count over 255 means bus-off; 128 bus-free events outside reset mode recover it
// - receive, transmit, overrun flags set on rising status when enabled
// - error flag sets on any warning or bus-off change when enabled
// - enabled conditions drive the cpu interrupt line
//
// Implementation choice: register access over APB.
module cem_ctrl
    import cem_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic tx_started_i,
    input wire logic tx_done_i,
    input wire logic tx_active_i,
    input wire logic rx_active_i,
    input wire logic rx_fifo_nonempty_i,
    input wire logic rx_win_load_i,
    input wire logic rx_win_overrun_i,
    input wire logic overload_frame_i,
    input wire logic data_frame_i,
    input wire logic [3:0] tx_err_inc_i,
    input wire logic tx_err_dec_i,
    input wire logic [3:0] rx_err_inc_i,
    input wire logic rx_err_dec_i,
    input wire logic bus_free_i,
    output logic reset_mode_o,
    output logic ack_enable_o,
    output logic loopback_check_mode_o,
    output logic dual_filter_select_o,
    output logic tx_req_o,
    output logic tx_single_shot_o,
    output logic tx_self_rx_o,
    output logic release_rx_o,
    output logic cpu_irq_line_o
);
    logic [7:0] mode_ff;
    logic [3:0] ien_ff;
    logic [3:0] iflag_ff;
    logic [7:0] wlimit_ff;
    logic [8:0] tec_ff;
    logic [7:0] rec_ff;
    logic [7:0] bfree_ff;
    logic bus_off_ff, overrun_ff, overload_ff, rx_pend_ff, warn_ff, ack_ff;
    logic [7:0] st_prev_ff;
    logic pready_ff, pslverr_ff, single_ff, self_rx_ff, release_ff, irq_ff;
    logic [31:0] prdata_ff;
    cem_tx_state_e tx_st_ff;
    cem_tx_state_e nxt_tx_st;
    logic acc, wr, rd, mapped, in_reset, cmd_wr;
    logic tx_ask, recov_done, boff_event, tx_req_ff;
    logic [3:0] idx;
    logic [7:0] status;
    logic [3:0] iset;

    // the access completes on the edge where pready is seen high
    assign acc = psel_i && penable_i && pready_ff;
    assign wr = acc && pwrite_i;
    assign rd = acc && !pwrite_i;
    assign idx = paddr_i[5:2];
    assign mapped = (paddr_i[7:6] == 2'b00) && (paddr_i[1:0] == 2'b00)
        && (idx <= IDX_INTERRUPT_ENABLES || idx >= IDX_WARNING_LIMIT);
    assign in_reset = mode_ff[MC_RESET];
    assign cmd_wr = wr && idx == IDX_COMMAND && mapped && !in_reset;
    assign tx_ask = pwdata_i[CMD_TX] || pwdata_i[CMD_SELF_RX];
    assign boff_event = tec_ff[8] && !bus_off_ff;
    assign recov_done = bus_off_ff && !in_reset && bus_free_i
        && bfree_ff == BUS_FREE_COUNT - 8'h01;

    always_comb
    begin
        status = 8'h00;
        status[ST_RX_PEND] = rx_pend_ff;
        status[ST_OVERRUN] = overrun_ff;
        status[ST_TX_FREE] = (tx_st_ff == TX_IDLE);
        status[ST_OVERLOAD] = overload_ff;
        status[ST_RX_ACT] = rx_active_i;
        status[ST_TX_ACT] = tx_active_i;
        status[ST_WARN] = warn_ff;
        status[ST_BUS_OFF] = bus_off_ff;
    end

    // apb: one wait state, then pready for one cycle
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= psel_i && penable_i && !pready_ff;
            pslverr_ff <= psel_i && penable_i && !pready_ff && !mapped;
            prdata_ff <= 32'h0000_0000;
            if (psel_i && penable_i && !pready_ff && !pwrite_i && mapped)
            begin
                case (idx)
                    IDX_MODE_CONTROL: prdata_ff[7:0] <= mode_ff;
                    IDX_STATUS: prdata_ff[7:0] <= status;
                    IDX_INTERRUPT_FLAGS: prdata_ff[3:0] <= iflag_ff;
                    IDX_INTERRUPT_ENABLES: prdata_ff[3:0] <= ien_ff;
                    // hidden outside reset mode
                    IDX_WARNING_LIMIT:
                        prdata_ff[7:0] <= in_reset ? wlimit_ff : 8'h00;
                    IDX_RX_ERROR_COUNT:
                        prdata_ff[7:0] <= in_reset ? rec_ff : 8'h00;
                    IDX_TX_ERROR_COUNT:
                        prdata_ff[7:0] <= in_reset ? tec_ff[7:0] : 8'h00;
                    default: prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // mode control; option bits change only while already in reset mode
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mode_ff <= MODE_RESET_VAL;
            ack_ff <= 1'b1;
        end
        else
        begin
            if (wr && mapped && idx == IDX_MODE_CONTROL)
            begin
                mode_ff[MC_RESET] <= pwdata_i[MC_RESET];
                if (in_reset)
                begin
                    mode_ff[MC_LISTEN] <= pwdata_i[MC_LISTEN];
                    ack_ff <= !pwdata_i[MC_LISTEN];
                    mode_ff[MC_LOOPBACK] <= pwdata_i[MC_LOOPBACK];
                    mode_ff[MC_DUAL] <= pwdata_i[MC_DUAL];
                end
            end
            // hardware set beats a software clear in the same cycle
            if (boff_event)
                mode_ff[MC_RESET] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ien_ff <= 4'h0;
            wlimit_ff <= WARN_LIMIT_RESET;
        end
        else
        begin
            if (wr && mapped && idx == IDX_INTERRUPT_ENABLES)
                ien_ff <= pwdata_i[3:0];
            if (wr && mapped && idx == IDX_WARNING_LIMIT && in_reset)
                wlimit_ff <= pwdata_i[7:0];
        end
    end

    // transmit request sequencing
    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        case (tx_st_ff)
            TX_IDLE:
                if (cmd_wr && tx_ask)
                    nxt_tx_st = TX_PEND;
            TX_PEND:
                if (cmd_wr && pwdata_i[CMD_CANCEL])
                    nxt_tx_st = TX_IDLE;
                else if (tx_started_i)
                    nxt_tx_st = TX_BUSY;
            TX_BUSY:
                if (tx_done_i)
                    nxt_tx_st = TX_IDLE;
            default: nxt_tx_st = TX_IDLE;
        endcase
        if (in_reset)
            nxt_tx_st = TX_IDLE;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_st_ff <= TX_IDLE;
            single_ff <= 1'b0;
            self_rx_ff <= 1'b0;
            tx_req_ff <= 1'b0;
        end
        else
        begin
            tx_st_ff <= nxt_tx_st;
            tx_req_ff <= (nxt_tx_st != TX_IDLE);
            if (tx_st_ff == TX_IDLE && cmd_wr && tx_ask)
            begin
                single_ff <= pwdata_i[CMD_CANCEL];
                // transmit bit with it wins, as does loopback mode off
                self_rx_ff <= pwdata_i[CMD_SELF_RX] && !pwdata_i[CMD_TX]
                    && mode_ff[MC_LOOPBACK];
            end
            else if (tx_started_i || nxt_tx_st == TX_IDLE)
            begin
                // self reception only on the first attempt
                self_rx_ff <= 1'b0;
            end
            if (nxt_tx_st == TX_IDLE)
                single_ff <= 1'b0;
        end
    end

    // receive side status
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            release_ff <= 1'b0;
            rx_pend_ff <= 1'b0;
            overrun_ff <= 1'b0;
            overload_ff <= 1'b0;
        end
        else
        begin
            release_ff <= cmd_wr && pwdata_i[CMD_RELEASE];
            // drop at release, pick the fifo level up again next cycle
            rx_pend_ff <= rx_fifo_nonempty_i && !release_ff;
            if (rx_win_load_i)
                overrun_ff <= rx_win_overrun_i;
            else if (cmd_wr && pwdata_i[CMD_CLR_OVR])
                overrun_ff <= 1'b0;
            if (overload_frame_i)
                overload_ff <= 1'b1;
            else if (data_frame_i)
                overload_ff <= 1'b0;
        end
    end

    // error counters; frozen in listen-only and in reset mode
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tec_ff <= 9'h000;
            rec_ff <= 8'h00;
            warn_ff <= 1'b0;
            bus_off_ff <= 1'b0;
            bfree_ff <= 8'h00;
        end
        else
        begin
            warn_ff <= (rec_ff >= wlimit_ff)
                || (tec_ff >= {1'b0, wlimit_ff});
            if (boff_event)
            begin
                bus_off_ff <= 1'b1;
                rec_ff <= 8'h00;
                bfree_ff <= 8'h00;
            end
            else if (recov_done)
            begin
                bus_off_ff <= 1'b0;
                tec_ff <= 9'h000;
                rec_ff <= 8'h00;
                warn_ff <= 1'b0;
            end
            else if (bus_off_ff)
            begin
                if (!in_reset && bus_free_i)
                    bfree_ff <= bfree_ff + 8'h01;
            end
            else if (in_reset)
            begin
                if (wr && mapped && idx == IDX_TX_ERROR_COUNT)
                    tec_ff <= {1'b0, pwdata_i[7:0]};
                if (wr && mapped && idx == IDX_RX_ERROR_COUNT)
                    rec_ff <= pwdata_i[7:0];
            end
            else if (!mode_ff[MC_LISTEN])
            begin
                if (tx_err_inc_i != 4'h0)
                    tec_ff <= tec_ff + {5'h00, tx_err_inc_i};
                else if (tx_err_dec_i && tec_ff != 9'h000)
                    tec_ff <= tec_ff - 9'h001;
                if (rx_err_inc_i != 4'h0)
                    rec_ff <= (rec_ff > COUNT_MAX - {4'h0, rx_err_inc_i})
                        ? COUNT_MAX : rec_ff + {4'h0, rx_err_inc_i};
                else if (rx_err_dec_i && rec_ff != 8'h00)
                    rec_ff <= rec_ff - 8'h01;
            end
        end
    end

    // interrupt flags: edge events on status, cleared by reading
    always_comb
    begin
        iset = 4'h0;
        iset[IF_RX] = status[ST_RX_PEND] && !st_prev_ff[ST_RX_PEND];
        iset[IF_TX] = status[ST_TX_FREE] && !st_prev_ff[ST_TX_FREE];
        iset[IF_OVR] = status[ST_OVERRUN] && !st_prev_ff[ST_OVERRUN];
        iset[IF_ERR] = (status[ST_WARN] != st_prev_ff[ST_WARN])
            || (status[ST_BUS_OFF] != st_prev_ff[ST_BUS_OFF]);
        iset = iset & ien_ff;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_prev_ff <= 8'h04;
            iflag_ff <= 4'h0;
            irq_ff <= 1'b0;
        end
        else
        begin
            st_prev_ff <= status;
            // only bits shown in the read data clear; later events survive
            if (rd && mapped && idx == IDX_INTERRUPT_FLAGS)
                iflag_ff <= (iflag_ff & ~prdata_ff[3:0]) | iset;
            else
                iflag_ff <= iflag_ff | iset;
            irq_ff <= |(iflag_ff & IRQ_MASK);
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign reset_mode_o = mode_ff[MC_RESET];
    assign ack_enable_o = ack_ff;
    assign loopback_check_mode_o = mode_ff[MC_LOOPBACK];
    assign dual_filter_select_o = mode_ff[MC_DUAL];
    assign tx_req_o = tx_req_ff;
    assign tx_single_shot_o = single_ff;
    assign tx_self_rx_o = self_rx_ff;
    assign release_rx_o = release_ff;
    assign cpu_irq_line_o = irq_ff;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_boff_enter;
        !bus_off_ff ##1 bus_off_ff;
    endsequence

    a_boff_forces_reset: assert property (s_boff_enter |-> in_reset)
        else $error("bus-off did not force reset mode");
    a_reset_cmd_kills: assert property (in_reset |=> tx_st_ff == TX_IDLE)
        else $error("reset mode left a transmit pending");
    a_tx_cmd_pends: assert property ((cmd_wr && tx_ask && tx_st_ff == TX_IDLE)
        |=> tx_req_o && !status[ST_TX_FREE])
        else $error("transmit command not taken");
    a_cancel_pending: assert property ((cmd_wr && pwdata_i[CMD_CANCEL]
        && tx_st_ff == TX_PEND && !in_reset) |=> tx_st_ff == TX_IDLE)
        else $error("cancel did not drop pending request");
    a_tx_irq_after: assert property ((ien_ff[IF_TX] && iset[IF_TX])
        |=> iflag_ff[IF_TX])
        else $error("transmit flag not set");
    a_release_pulse: assert property (release_ff |=> !release_ff ##0 !rx_pend_ff)
        else $error("release pulse or pending drop wrong");
    a_listen_freeze: assert property ((mode_ff[MC_LISTEN] && !in_reset
        && !boff_event && !recov_done) |=> $stable(tec_ff) && $stable(rec_ff))
        else $error("counters moved in listen-only");
    a_warn_level: assert property (($past(rec_ff) >= $past(wlimit_ff))
        && !$past(recov_done) |-> warn_ff)
        else $error("warning flag missing");
    a_irq_follows: assert property (iflag_ff != 4'h0 |=> cpu_irq_line_o)
        else $error("interrupt line low with flag set");
    a_err_disabled: assert property (!ien_ff[IF_ERR] && !iflag_ff[IF_ERR]
        |=> !iflag_ff[IF_ERR])
        else $error("disabled error flag rose");
    a_recover_clears: assert property (recov_done |=> !bus_off_ff
        && tec_ff == 9'h000 && rec_ff == 8'h00)
        else $error("bus-off recovery incomplete");
endmodule

// ==== cem_engine_model.sv ====
// stand-in for the serial engine: starts an attempt after a short or a long
// wait, stays busy for a fixed frame length, then reports completion
module cem_engine_model
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic tx_req_i,
    input wire logic reset_mode_i,
    input wire logic slow_i,
    output logic tx_started_o,
    output logic tx_done_o,
    output logic tx_active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_ff;
    logic busy_ff;

    assign tx_active_o = busy_ff;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_ff <= 8'h00;
            busy_ff <= 1'b0;
            tx_started_o <= 1'b0;
            tx_done_o <= 1'b0;
        end
        else
        begin
            tx_started_o <= 1'b0;
            tx_done_o <= 1'b0;
            // reset mode drops a frame in flight without a completion
            if (reset_mode_i)
            begin
                busy_ff <= 1'b0;
                cnt_ff <= 8'h00;
            end
            else if (busy_ff)
            begin
                cnt_ff <= cnt_ff + 8'h01;
                if (cnt_ff == 8'h08)
                begin
                    tx_done_o <= 1'b1;
                    busy_ff <= 1'b0;
                    cnt_ff <= 8'h00;
                end
            end
            else if (tx_req_i && !tx_done_o)
            begin
                // slow start leaves room for a cancel before the attempt
                cnt_ff <= cnt_ff + 8'h01;
                if (cnt_ff == (slow_i ? 8'h28 : 8'h02))
                begin
                    tx_started_o <= 1'b1;
                    busy_ff <= 1'b1;
                    cnt_ff <= 8'h00;
                end
            end
            else
                cnt_ff <= 8'h00;
        end
    end
endmodule

// ==== can_ext_mode_ctrl_status_tb_top.sv ====
module can_ext_mode_ctrl_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cem_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, rx_active_i = 1'b0, rx_fifo_nonempty_i = 1'b0;
    logic rx_win_load_i = 1'b0, rx_win_overrun_i = 1'b0, slow = 1'b0;
    logic overload_frame_i = 1'b0, data_frame_i = 1'b0, bus_free_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
    logic [3:0] tx_err_inc_i = 4'h0, rx_err_inc_i = 4'h0;
    logic pready_o, pslverr_o, tx_started_i, tx_done_i, tx_active_i, rerr;
    logic reset_mode_o, ack_enable_o, loopback_check_mode_o, tx_req_o;
    logic dual_filter_select_o, tx_single_shot_o, tx_self_rx_o;
    logic release_rx_o, cpu_irq_line_o;
    int n_fail = 0;
    int checks = 0;
    int rel_seen = 0;

    cem_ctrl DUT (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_started_i,
        .tx_done_i, .tx_active_i, .rx_active_i, .rx_fifo_nonempty_i,
        .rx_win_load_i, .rx_win_overrun_i, .overload_frame_i, .data_frame_i,
        .tx_err_inc_i, .tx_err_dec_i(1'b0), .rx_err_inc_i,
        .rx_err_dec_i(1'b0), .bus_free_i, .reset_mode_o, .ack_enable_o,
        .loopback_check_mode_o, .dual_filter_select_o, .tx_req_o,
        .tx_single_shot_o, .tx_self_rx_o, .release_rx_o, .cpu_irq_line_o);

    cem_engine_model u_engine (.clk_i, .rst_b_i, .tx_req_i(tx_req_o),
        .reset_mode_i(reset_mode_o), .slow_i(slow),
        .tx_started_o(tx_started_i), .tx_done_o(tx_done_i),
        .tx_active_o(tx_active_i));

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) if (release_rx_o === 1'b1) rel_seen++;

    task automatic close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [3:0] idx,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && n < 16)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 16) n_fail++;
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [3:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(rdat, {24'h0, e});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (tx_req_o !== 1'b0 && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        cyc(1);
        chk({31'h0, tx_req_o}, 32'h0);
    endtask

    task automatic bus_free(input int n);
        repeat (n)
        begin
            bus_free_i <= 1'b1;
            cyc(1);
            bus_free_i <= 1'b0;
            cyc(1);
        end
    endtask

    task automatic s_reset;
        chk({31'h0, reset_mode_o}, 32'h1);
        chk({31'h0, ack_enable_o}, 32'h1);
        rd(IDX_MODE_CONTROL, MODE_RESET_VAL);
        rd(IDX_WARNING_LIMIT, WARN_LIMIT_RESET);
        rd(IDX_COMMAND, 8'h00);
    endtask

    task automatic s_mode;
        wr(IDX_MODE_CONTROL, 8'h0F);
        rd(IDX_MODE_CONTROL, 8'h0F);
        chk({31'h0, ack_enable_o}, 32'h0);
        chk({31'h0, loopback_check_mode_o}, 32'h1);
        chk({31'h0, dual_filter_select_o}, 32'h1);
        // limit 84 lets seven increments of twelve land exactly on it
        wr(IDX_WARNING_LIMIT, 8'h54);
        rd(IDX_WARNING_LIMIT, 8'h54);
        // leave reset with listen-only kept; these errors must not count
        wr(IDX_MODE_CONTROL, 8'h02);
        cyc(1);
        chk({31'h0, reset_mode_o}, 32'h0);
        rx_err_inc_i <= 4'hF;
        cyc(1);
        rx_err_inc_i <= 4'h0;
        wr(IDX_MODE_CONTROL, 8'h0E);
        rd(IDX_MODE_CONTROL, 8'h02);
        wr(IDX_WARNING_LIMIT, 8'h33);
        rd(IDX_WARNING_LIMIT, 8'h00);
        apb(1'b0, 4'h5, 8'h00);
        chk({31'h0, rerr}, 32'h1);
        wr(IDX_INTERRUPT_ENABLES, 8'h0F);
        rd(IDX_INTERRUPT_ENABLES, 8'h0F);
        apb(1'b0, IDX_INTERRUPT_FLAGS, 8'h00);
    endtask

    task automatic s_tx;
        wr(IDX_COMMAND, 8'h00);
        cyc(2);
        chk({31'h0, tx_req_o}, 32'h0);
        wr(IDX_COMMAND, 8'h01);
        cyc(1);
        chk({31'h0, tx_req_o}, 32'h1);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rdat & 32'h24, 32'h20);
        wait_idle();
        cyc(2);
        rd(IDX_STATUS, 8'h04);
        chk({31'h0, cpu_irq_line_o}, 32'h1);
        rd(IDX_INTERRUPT_FLAGS, 8'h02);
        cyc(2);
        chk({31'h0, cpu_irq_line_o}, 32'h0);
        rd(IDX_INTERRUPT_FLAGS, 8'h00);
    endtask

    task automatic s_cancel;
        slow <= 1'b1;
        wr(IDX_COMMAND, 8'h01);
        wr(IDX_COMMAND, 8'h02);
        cyc(2);
        chk({31'h0, tx_req_o}, 32'h0);
        rd(IDX_INTERRUPT_FLAGS, 8'h02);
        slow <= 1'b0;
        wr(IDX_COMMAND, 8'h03);
        cyc(1);
        chk({31'h0, tx_single_shot_o}, 32'h1);
        chk({31'h0, tx_req_o}, 32'h1);
        wait_idle();
        rd(IDX_INTERRUPT_FLAGS, 8'h02);
    endtask

    task automatic s_self;
        wr(IDX_COMMAND, 8'h10);
        cyc(1);
        chk({31'h0, tx_req_o}, 32'h1);
        chk({31'h0, tx_self_rx_o}, 32'h0);
        wait_idle();
        slow <= 1'b1;
        wr(IDX_COMMAND, 8'h01);
        wr(IDX_MODE_CONTROL, 8'h05);
        cyc(2);
        chk({31'h0, tx_req_o}, 32'h0);
        slow <= 1'b0;
        wr(IDX_MODE_CONTROL, 8'h04);
        cyc(1);
        chk({31'h0, loopback_check_mode_o}, 32'h1);
        wr(IDX_COMMAND, 8'h11);
        cyc(1);
        chk({31'h0, tx_self_rx_o}, 32'h0);
        wait_idle();
        wr(IDX_COMMAND, 8'h10);
        cyc(1);
        chk({31'h0, tx_self_rx_o}, 32'h1);
        wait_idle();
        chk({31'h0, tx_self_rx_o}, 32'h0);
        wr(IDX_MODE_CONTROL, 8'h01);
        wr(IDX_MODE_CONTROL, 8'h00);
        apb(1'b0, IDX_INTERRUPT_FLAGS, 8'h00);
    endtask

    task automatic s_rx;
        int n0;
        rx_fifo_nonempty_i <= 1'b1;
        cyc(3);
        rd(IDX_STATUS, 8'h05);
        rd(IDX_INTERRUPT_FLAGS, 8'h01);
        n0 = rel_seen;
        wr(IDX_COMMAND, 8'h04);
        cyc(3);
        chk(rel_seen - n0, 32'h1);
        rd(IDX_STATUS, 8'h05);
        rx_fifo_nonempty_i <= 1'b0;
        cyc(2);
        rd(IDX_STATUS, 8'h04);
        rx_win_load_i <= 1'b1;
        rx_win_overrun_i <= 1'b1;
        cyc(1);
        rx_win_load_i <= 1'b0;
        rx_win_overrun_i <= 1'b0;
        cyc(2);
        rd(IDX_STATUS, 8'h06);
        rd(IDX_INTERRUPT_FLAGS, 8'h09);
        wr(IDX_COMMAND, 8'h08);
        wr(IDX_COMMAND, 8'h04);
        cyc(2);
        rd(IDX_STATUS, 8'h04);
        overload_frame_i <= 1'b1;
        rx_active_i <= 1'b1;
        cyc(1);
        overload_frame_i <= 1'b0;
        cyc(2);
        rd(IDX_STATUS, 8'h1C);
        data_frame_i <= 1'b1;
        rx_active_i <= 1'b0;
        cyc(1);
        data_frame_i <= 1'b0;
        cyc(2);
        rd(IDX_STATUS, 8'h04);
    endtask

    task automatic s_err;
        rx_err_inc_i <= 4'hC;
        cyc(6);
        rx_err_inc_i <= 4'h0;
        cyc(2);
        rd(IDX_STATUS, 8'h04);
        rx_err_inc_i <= 4'hC;
        cyc(1);
        rx_err_inc_i <= 4'h0;
        cyc(2);
        rd(IDX_STATUS, 8'h44);
        rd(IDX_INTERRUPT_FLAGS, 8'h04);
        tx_err_inc_i <= 4'hF;
        cyc(17);
        tx_err_inc_i <= 4'h0;
        cyc(2);
        chk({31'h0, reset_mode_o}, 32'h0);
        tx_err_inc_i <= 4'hF;
        cyc(1);
        tx_err_inc_i <= 4'h0;
        cyc(2);
        chk({31'h0, reset_mode_o}, 32'h1);
        rd(IDX_STATUS, 8'hC4);
        rd(IDX_INTERRUPT_FLAGS, 8'h04);
        wr(IDX_MODE_CONTROL, 8'h00);
        bus_free(127);
        rd(IDX_STATUS, 8'hC4);
        bus_free(1);
        cyc(2);
        rd(IDX_STATUS, 8'h04);
        rd(IDX_INTERRUPT_FLAGS, 8'h04);
    endtask

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        cyc(1);
        s_reset();
        s_mode();
        s_tx();
        s_cancel();
        s_self();
        s_rx();
        s_err();
        close_out();
    end

    // whole sequence needs well under a thousand cycles
    initial
    begin
        #(25 * 20000);
        n_fail++;
        close_out();
    end
endmodule
